// file: design/pim_pkg.sv
// constants, field positions and types for the per-port gate and
// operation control register bank.
// assumes an 8-bit register offset local to one port, 8-bit data.
package pim_pkg;

	// ---------------------------------------------------------------
	// register offsets, local to one port
	// ---------------------------------------------------------------
	localparam int unsigned PIM_ADDR_W = 8;
	localparam int unsigned PIM_DATA_W = 8;
	localparam int unsigned PIM_SRC_N = 4;
	localparam logic [7:0] PIM_OFS_IRQ_STATUS = 8'h1b;
	localparam logic [7:0] PIM_OFS_IRQ_GATE = 8'h1f;
	localparam logic [7:0] PIM_OFS_OP_CTRL = 8'h20;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned PIM_SRC_SGMII = 3;
	localparam int unsigned PIM_SRC_PTP = 2;
	localparam int unsigned PIM_SRC_PHY = 1;
	localparam int unsigned PIM_SRC_ACL = 0;
	localparam int unsigned PIM_OPC_LOCAL_LB = 7;
	localparam int unsigned PIM_OPC_REMOTE_LB = 6;
	localparam int unsigned PIM_OPC_TAIL_TAG = 2;
	localparam int unsigned PIM_OPC_QSPLIT_LO = 0;
	localparam int unsigned PIM_SGMII_PORT = 7;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [3:0] PIM_GATE_RST = 4'h0;
	localparam logic [3:0] PIM_STATUS_RST = 4'h0;
	localparam logic [7:0] PIM_RDATA_RST = 8'h00;

	typedef enum logic [1:0] {
		PIM_QS_ONE = 2'b00,
		PIM_QS_TWO = 2'b01,
		PIM_QS_FOUR = 2'b10,
		PIM_QS_RSVD = 2'b11
	} pim_qsplit_t;

	// which interrupt sources exist on a given port
	function automatic logic [3:0] pim_src_impl(input int unsigned port,
		input logic has_phy);
		logic [3:0] impl;
		impl = 4'h0;
		impl[PIM_SRC_ACL] = 1'b1;
		impl[PIM_SRC_PHY] = has_phy;
		impl[PIM_SRC_PTP] = has_phy;
		impl[PIM_SRC_SGMII] = (port == PIM_SGMII_PORT);
		return impl;
	endfunction

endpackage

// file: design/pim_irq_bank.sv
// sticky interrupt status with inverted-polarity gating.
// assumes event, clear, gate and impl inputs are synchronous.
`timescale 1ns/10ps
module pim_irq_bank #(
	parameter int unsigned N = 4
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [N-1:0] event_in,
	input wire logic [N-1:0] clear_in,
	input wire logic [N-1:0] gate_in,
	input wire logic [N-1:0] impl_in,
	output logic [N-1:0] status_out,
	output logic irq_out
);
	typedef struct packed {
		logic [N-1:0] status;
		logic irq;
	} pim_irq_state_t;

	pim_irq_state_t st_q;
	pim_irq_state_t st_d;

	always_comb begin
		st_d = st_q;
		// set wins over a clear in the same cycle
		st_d.status = ((st_q.status & ~clear_in) | event_in) & impl_in;
		st_d.irq = |(st_d.status & ~gate_in & impl_in); // [R14] [R2]
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign status_out = st_q.status;
	assign irq_out = st_q.irq;
endmodule

// file: design/pim_loop_path.sv
// local and remote loopback steering for one port's data path.
// assumes data words with a valid qualifier, one word per cycle.
`timescale 1ns/10ps
module pim_loop_path #(
	parameter int unsigned W = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic local_lb_in,
	input wire logic remote_lb_in,
	input wire logic [W-1:0] ext_rx_data_in,
	input wire logic ext_rx_valid_in,
	input wire logic [W-1:0] fab_egress_data_in,
	input wire logic fab_egress_valid_in,
	output logic [W-1:0] ext_tx_data_out,
	output logic ext_tx_valid_out,
	output logic [W-1:0] fab_ingress_data_out,
	output logic fab_ingress_valid_out
);
	typedef struct packed {
		logic [W-1:0] tx_data;
		logic tx_valid;
		logic [W-1:0] in_data;
		logic in_valid;
	} pim_loop_state_t;

	pim_loop_state_t st_q;
	pim_loop_state_t st_d;

	always_comb begin
		st_d = st_q;
		// toward the pins: remote turnaround, else fabric unless local
		if (remote_lb_in) begin
			st_d.tx_data = ext_rx_data_in; // [R7] [R8]
			st_d.tx_valid = ext_rx_valid_in; // [R7] [R8]
		end else begin
			st_d.tx_data = fab_egress_data_in;
			st_d.tx_valid = fab_egress_valid_in & ~local_lb_in; // [R6]
		end
		// toward the fabric: local turnaround, else pins unless remote
		if (local_lb_in) begin
			st_d.in_data = fab_egress_data_in; // [R6]
			st_d.in_valid = fab_egress_valid_in; // [R6]
		end else begin
			st_d.in_data = ext_rx_data_in;
			st_d.in_valid = ext_rx_valid_in & ~remote_lb_in; // [R7]
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ext_tx_data_out = st_q.tx_data;
	assign ext_tx_valid_out = st_q.tx_valid;
	assign fab_ingress_data_out = st_q.in_data;
	assign fab_ingress_valid_out = st_q.in_valid;
endmodule

// file: design/pim_port_regs.sv
// per-port interrupt gate and operation control registers, with the
// sticky interrupt status and the loopback steering they control.
// assumes a synchronous register port: one-cycle strobes, read data
// in the cycle after the read strobe; all inputs synchronous.
//
// Notes on behaviour
// R1: four-bit gate register per port, per-source
// R2: gate bit one blocks; resets to zero
// R3: sgmii gate bit effective on port seven only
// R4: ptp and phy gate bits need phy
// R5: acl gate bit exists on every port
// R6: bit seven loops fabric egress back in
// R7: bit six loops pin receive back out
// R8: phy pair or media independent pins turn
// R9: bit two marks host port, tail tagging
// R10: software enables tail tagging on one port
// R11: bits one:zero pick one, two, four queues
// R12: reserved bits read zero, ignore writes
// R13: toggling acl gate bit clears acl status
// R14: interrupt while ungated status bit set
`timescale 1ns/10ps
module pim_port_regs
	import pim_pkg::*;
#(
	parameter int unsigned PORT_NUM = 1,
	parameter bit HAS_PHY = 1'b1,
	parameter int unsigned DATA_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [PIM_ADDR_W-1:0] reg_addr_in,
	input wire logic [PIM_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [PIM_DATA_W-1:0] reg_rdata_out,
	input wire logic sgmii_an_done_in,
	input wire logic ptp_summary_in,
	input wire logic phy_summary_in,
	input wire logic acl_event_in,
	output logic irq_out,
	output logic local_loopback_out,
	output logic remote_loopback_out,
	output logic tail_tag_out,
	output logic [1:0] queue_split_out,
	input wire logic [DATA_W-1:0] ext_rx_data_in,
	input wire logic ext_rx_valid_in,
	input wire logic [DATA_W-1:0] fab_egress_data_in,
	input wire logic fab_egress_valid_in,
	output logic [DATA_W-1:0] ext_tx_data_out,
	output logic ext_tx_valid_out,
	output logic [DATA_W-1:0] fab_ingress_data_out,
	output logic fab_ingress_valid_out
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] gate;
		logic local_lb;
		logic remote_lb;
		logic tail_tag;
		pim_qsplit_t qsplit;
		logic [PIM_DATA_W-1:0] rdata;
	} pim_regs_state_t;

	localparam logic [3:0] SRC_IMPL = pim_src_impl(PORT_NUM, HAS_PHY);

	pim_regs_state_t st_q;
	pim_regs_state_t st_d;
	logic [3:0] status;
	logic [3:0] events;
	logic [3:0] clear;
	logic wr_gate;
	logic wr_opc;
	logic wr_status;
	logic [1:0] qs_wr;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	assign wr_gate = reg_wr_in && (reg_addr_in == PIM_OFS_IRQ_GATE);
	assign wr_opc = reg_wr_in && (reg_addr_in == PIM_OFS_OP_CTRL);
	assign wr_status = reg_wr_in && (reg_addr_in == PIM_OFS_IRQ_STATUS);
	assign qs_wr = reg_wdata_in[PIM_OPC_QSPLIT_LO +: 2];

	assign events[PIM_SRC_SGMII] = sgmii_an_done_in;
	assign events[PIM_SRC_PTP] = ptp_summary_in;
	assign events[PIM_SRC_PHY] = phy_summary_in;
	assign events[PIM_SRC_ACL] = acl_event_in;

	always_comb begin
		clear = 4'h0;
		if (wr_status) begin
			clear = reg_wdata_in[3:0];
		end
		// a change of the acl gate bit clears acl status
		if (wr_gate &&
			(reg_wdata_in[PIM_SRC_ACL] != st_q.gate[PIM_SRC_ACL])) begin
			clear[PIM_SRC_ACL] = 1'b1; // [R13]
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (wr_gate) begin
			st_d.gate = reg_wdata_in[3:0]; // [R1] [R12]
		end
		if (wr_opc) begin
			st_d.local_lb = reg_wdata_in[PIM_OPC_LOCAL_LB]; // [R6]
			st_d.remote_lb = reg_wdata_in[PIM_OPC_REMOTE_LB]; // [R7]
			st_d.tail_tag = reg_wdata_in[PIM_OPC_TAIL_TAG]; // [R9]
			// reserved code leaves the queue split unchanged
			if (qs_wr != PIM_QS_RSVD) begin
				st_d.qsplit = pim_qsplit_t'(qs_wr); // [R11]
			end
		end
		st_d.rdata = PIM_RDATA_RST;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				PIM_OFS_IRQ_GATE: begin
					st_d.rdata = {4'h0, st_q.gate}; // [R12]
				end
				PIM_OFS_OP_CTRL: begin
					st_d.rdata = {st_q.local_lb, st_q.remote_lb, 3'h0,
						st_q.tail_tag, st_q.qsplit}; // [R12]
				end
				PIM_OFS_IRQ_STATUS: begin
					st_d.rdata = {4'h0, status};
				end
				default: begin
					st_d.rdata = PIM_RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q.gate <= PIM_GATE_RST; // [R2]
			st_q.local_lb <= 1'b0;
			st_q.remote_lb <= 1'b0;
			st_q.tail_tag <= 1'b0;
			st_q.qsplit <= PIM_QS_ONE;
			st_q.rdata <= PIM_RDATA_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// interrupt status and gating
	// ---------------------------------------------------------------
	// sources absent on this port never set and never gate
	pim_irq_bank #(
		.N(PIM_SRC_N)
	) u_irq (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.event_in(events),
		.clear_in(clear),
		.gate_in(st_q.gate),
		.impl_in(SRC_IMPL), // [R3] [R4] [R5]
		.status_out(status),
		.irq_out(irq_out)
	);

	// ---------------------------------------------------------------
	// loopback steering
	// ---------------------------------------------------------------
	pim_loop_path #(
		.W(DATA_W)
	) u_loop (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.local_lb_in(st_q.local_lb),
		.remote_lb_in(st_q.remote_lb),
		.ext_rx_data_in(ext_rx_data_in),
		.ext_rx_valid_in(ext_rx_valid_in),
		.fab_egress_data_in(fab_egress_data_in),
		.fab_egress_valid_in(fab_egress_valid_in),
		.ext_tx_data_out(ext_tx_data_out),
		.ext_tx_valid_out(ext_tx_valid_out),
		.fab_ingress_data_out(fab_ingress_data_out),
		.fab_ingress_valid_out(fab_ingress_valid_out)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata_out = st_q.rdata;
	assign local_loopback_out = st_q.local_lb;
	assign remote_loopback_out = st_q.remote_lb;
	assign tail_tag_out = st_q.tail_tag;
	assign queue_split_out = st_q.qsplit;
endmodule

// file: testbench/pim_port_regs_chk.sv
// concurrent checks on the ports of the per-port register bank.
// assumes one clock and the register and data path timing of the notes.
`timescale 1ns/10ps
module pim_port_regs_chk
	import pim_pkg::*;
#(
	parameter int unsigned DATA_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [PIM_ADDR_W-1:0] reg_addr_in,
	input wire logic [PIM_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [PIM_DATA_W-1:0] reg_rdata_out,
	input wire logic sgmii_an_done_in,
	input wire logic ptp_summary_in,
	input wire logic phy_summary_in,
	input wire logic acl_event_in,
	input wire logic irq_out,
	input wire logic local_loopback_out,
	input wire logic remote_loopback_out,
	input wire logic tail_tag_out,
	input wire logic [1:0] queue_split_out,
	input wire logic [DATA_W-1:0] ext_rx_data_in,
	input wire logic ext_rx_valid_in,
	input wire logic [DATA_W-1:0] fab_egress_data_in,
	input wire logic fab_egress_valid_in,
	input wire logic [DATA_W-1:0] ext_tx_data_out,
	input wire logic ext_tx_valid_out,
	input wire logic [DATA_W-1:0] fab_ingress_data_out,
	input wire logic fab_ingress_valid_out
);
	// ---------------------------------------------------------------
	// helpers and assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic opw, rsv, opr, gtr, evany;
	logic [4:0] opv, ctl;
	assign opw = reg_wr_in && reg_addr_in == PIM_OFS_OP_CTRL;
	assign opr = reg_rd_in && reg_addr_in == PIM_OFS_OP_CTRL;
	assign gtr = reg_rd_in && reg_addr_in == PIM_OFS_IRQ_GATE;
	assign rsv = reg_wdata_in[1:0] == 2'b11;
	assign opv = {reg_wdata_in[7:6], reg_wdata_in[2:0]};
	assign ctl = {local_loopback_out, remote_loopback_out, tail_tag_out,
		queue_split_out};
	assign evany = sgmii_an_done_in | ptp_summary_in | phy_summary_in |
		acl_event_in;
	a_ctrl_write: assert property (
		opw && !rsv |=> ctl == $past(opv))
		else $error("control write not applied");
	a_qs_reserved: assert property (opw && rsv |=>
		$stable(queue_split_out)) else $error("reserved split taken");
	a_ctrl_hold: assert property (!opw |=> $stable(ctl))
		else $error("control changed without write");
	a_ctrl_read: assert property ($past(opr) |-> reg_rdata_out ==
		{ctl[4:3], 3'b000, ctl[2:0]}) else $error("control readback");
	a_gate_rsvd: assert property ($past(gtr) |->
		reg_rdata_out[7:4] == 4'h0) else $error("gate reserved bits");
	// a gate write reaches irq one cycle after the gate itself
	a_irq_cause: assert property ($rose(irq_out) |->
		$past(evany) || $past(reg_wr_in, 2))
		else $error("irq without cause");
	a_local_turn: assert property (local_loopback_out &&
		fab_egress_valid_in |=> fab_ingress_valid_out &&
		fab_ingress_data_out == $past(fab_egress_data_in))
		else $error("local loop lost word");
	a_remote_turn: assert property (remote_loopback_out &&
		ext_rx_valid_in |=> ext_tx_valid_out &&
		ext_tx_data_out == $past(ext_rx_data_in))
		else $error("remote loop lost word");
	c_irq: cover property (irq_out);
	c_both_lb: cover property (local_loopback_out && remote_loopback_out);
	c_rsvd_split: cover property (opw && rsv);
endmodule

// file: testbench/pim_port_regs_tb.sv
// self-checking bench for the register bank on port seven with a phy.
// assumes the register port timing and reset of the design notes.
`timescale 1ns/10ps
module pim_port_regs_tb;
	import pim_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, etv = 0, fev = 0;
	logic [7:0] addr = 0, wd = 0, etd = 0, fed = 0, rdat, txd, ind;
	logic [3:0] src = 0;
	logic irq, llb, rlb, tt, txv, inv;
	logic [1:0] qs;
	logic [7:0] rdat1;
	logic wr1, irq1;
	int fails = 0, check_count = 0, cyc = 0;
	always #5 clk = ~clk;
	pim_port_regs #(.PORT_NUM(7), .HAS_PHY(1'b1), .DATA_W(8)) i_dut (
		.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .sgmii_an_done_in(src[3]),
		.ptp_summary_in(src[2]), .phy_summary_in(src[1]),
		.acl_event_in(src[0]), .irq_out(irq), .local_loopback_out(llb),
		.remote_loopback_out(rlb), .tail_tag_out(tt),
		.queue_split_out(qs), .ext_rx_data_in(etd), .ext_rx_valid_in(etv),
		.fab_egress_data_in(fed), .fab_egress_valid_in(fev),
		.ext_tx_data_out(txd), .ext_tx_valid_out(txv),
		.fab_ingress_data_out(ind), .fab_ingress_valid_out(inv));
	// second port without phy; never sees control writes
	assign wr1 = wr && (addr != PIM_OFS_OP_CTRL);
	pim_port_regs #(.PORT_NUM(1), .HAS_PHY(1'b0), .DATA_W(8)) i_dut_p1 (
		.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr1), .reg_rd_in(rd),
		.reg_rdata_out(rdat1), .sgmii_an_done_in(src[3]),
		.ptp_summary_in(src[2]), .phy_summary_in(src[1]),
		.acl_event_in(src[0]), .irq_out(irq1), .local_loopback_out(),
		.remote_loopback_out(), .tail_tag_out(),
		.queue_split_out(), .ext_rx_data_in(etd), .ext_rx_valid_in(etv),
		.fab_egress_data_in(fed), .fab_egress_valid_in(fev),
		.ext_tx_data_out(), .ext_tx_valid_out(),
		.fab_ingress_data_out(), .fab_ingress_valid_out());
	// ---------------------------------------------------------------
	// access and compare tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [8:0] e, g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrr(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, {1'b0, e}, {1'b0, rdat});
	endtask
	task automatic ev(input int i);
		@(posedge clk);
		src <= 4'h1 << i;
		@(posedge clk);
		src <= 4'h0;
		#1;
	endtask
	task automatic clr(input int i);
		if (i == 0) begin
			wrr(PIM_OFS_IRQ_GATE, 8'h01);
			wrr(PIM_OFS_IRQ_GATE, 8'h00);
		end else
			wrr(PIM_OFS_IRQ_STATUS, 8'h01 << i);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [8:0] et, ei;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rdc("gate", PIM_OFS_IRQ_GATE, 8'h00);
		rdc("opctl", PIM_OFS_OP_CTRL, 8'h00);
		wrr(8'h55, 8'hff);
		rdc("unmapped", 8'h55, 8'h00);
		wrr(PIM_OFS_IRQ_GATE, 8'hff);
		rdc("gate", PIM_OFS_IRQ_GATE, 8'h0f);
		wrr(PIM_OFS_OP_CTRL, 8'hff);
		rdc("opctl", PIM_OFS_OP_CTRL, 8'hc4);
		chk("tail", 9'h1, {8'h0, tt});
		wrr(PIM_OFS_IRQ_GATE, 8'h00);
		for (int q = 0; q < 3; q++) begin
			wrr(PIM_OFS_OP_CTRL, q[7:0]);
			rdc("opctl", PIM_OFS_OP_CTRL, q[7:0]);
			chk("queues", q[8:0], {7'h0, qs});
		end
		for (int i = 0; i < 4; i++) begin
			ev(i);
			chk("irq", 9'h1, {8'h0, irq});
			chk("irq p1", {8'h0, i == 0}, {8'h0, irq1});
			rdc("status", PIM_OFS_IRQ_STATUS, 8'h01 << i);
			chk("status p1", {8'h0, i == 0}, {1'b0, rdat1});
			clr(i);
			chk("irq", 9'h0, {8'h0, irq});
			wrr(PIM_OFS_IRQ_GATE, 8'h01 << i);
			ev(i);
			chk("irq", 9'h0, {8'h0, irq});
			rdc("status", PIM_OFS_IRQ_STATUS, 8'h01 << i);
			// ungating a held source raises irq, except acl (toggle)
			wrr(PIM_OFS_IRQ_GATE, 8'h00);
			@(posedge clk);
			#1 chk("irq", {8'h0, i != 0}, {8'h0, irq});
			clr(i);
			wrr(PIM_OFS_IRQ_GATE, 8'h00);
			rdc("status", PIM_OFS_IRQ_STATUS, 8'h00);
		end
		for (int m = 0; m < 4; m++) begin
			wrr(PIM_OFS_OP_CTRL, {m[1:0], 6'h00});
			chk("loops", {7'h0, m[1:0]}, {7'h0, llb, rlb});
			et = m[0] ? 9'h13c : (m[1] ? 9'h000 : 9'h1a5);
			ei = m[1] ? 9'h1a5 : (m[0] ? 9'h000 : 9'h13c);
			@(posedge clk);
			etd <= 8'h3c;
			fed <= 8'ha5;
			etv <= 1'b1;
			fev <= 1'b1;
			@(posedge clk);
			etd <= 8'hc3;
			fed <= 8'h5a;
			etv <= 1'b0;
			fev <= 1'b0;
			#1 chk("to pins", et, {txv, txv ? txd : 8'h00});
			chk("to fabric", ei, {inv, inv ? ind : 8'h00});
		end
		ev(1);
		chk("irq", 9'h1, {8'h0, irq});
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1 chk("irq", 9'h0, {8'h0, irq});
		rdc("opctl", PIM_OFS_OP_CTRL, 8'h00);
		rdc("status", PIM_OFS_IRQ_STATUS, 8'h00);
		end_sim();
	end
endmodule
bind pim_port_regs pim_port_regs_chk #(.DATA_W(DATA_W)) i_chk (.*);
